// *** src/sms_cfg.svh ***
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH
`define SMS_RATIO_MSB 10
`define SMS_RATIO_LSB 8
`define SMS_FILT_MSB 7
`define SMS_FILT_LSB 5
`define SMS_RES_MSB 4
`define SMS_RES_LSB 3
`define SMS_OVS_MSB 2
`define SMS_OVS_LSB 0
`define SMS_CONV_MASK 16'h07ff
`define SMS_THR_MSB 12
`define SMS_THR_LSB 8
`define SMS_MODE_MSB 7
`define SMS_MODE_LSB 6
`define SMS_DLY_MSB 3
`define SMS_DLY_LSB 0
`define SMS_OPER_MASK 16'h1fcf
`define SMS_RESET_WORD 16'h0000
`define SMS_FIFO_DEPTH 32
`define SMS_CLK_HZ 10000000
`define SMS_BUSY_CYCLES 4
`endif

// *** src/sms_pkg.sv ***
`default_nettype none
package sms_pkg;
  typedef enum logic [1:0] {sms_fifo_off, sms_fifo_full, sms_fifo_update} sms_fifo_mode_t;
  typedef enum logic [2:0] {sms_idle, sms_wait, sms_conv_t, sms_conv_p, sms_store, sms_busy}
    sms_state_t;
endpackage
`default_nettype wire

// *** src/sms_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sms_mem_if #(parameter int AW = 5, parameter int DW = 48);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// *** src/sms_pair_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module sms_pair_mem #(
  parameter int AW = 5,
  parameter int DW = 48
) (
  input wire logic clk,
  sms_mem_if.mem port
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] next_rdata;
  logic [DW-1:0] rdata_q;

  always_comb
  begin
    next_rdata = store[port.raddr];
  end

  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
    rdata_q <= next_rdata;
  end

  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// *** src/sms_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sms_cfg.svh"
// Overview of operation
// RULE1 - Channel config: ratio 10:8, filter 7:5, resolution 4:3, oversampling 2:0.
// RULE2 - Ratio code: off,1,2,4,8,16, and 32 for codes six and seven.
// RULE3 - Filter code: off,2,4,8,16, then 32 for codes five to seven.
// RULE4 - Resolution: 24 bits, 16 bits, else 8 bits per read.
// RULE5 - Oversampling 0..6, code seven acts as six.
// RULE6 - Operation word: threshold 12:8, FIFO mode 7:6, delay 3:0.
// RULE7 - Delay code maps off,5ms..20s; thirteen and up give 60 s.
// RULE8 - Delay counts from end of one measurement to start of next.
// RULE9 - Nonzero delay starts auto mode unless both ratios off.
// RULE10 - Auto mode rejects start-conversion and write-config commands.
// RULE11 - Delay off stops triggers; running set finishes, counter resets.
// RULE12 - Channel converts when trigger count is multiple of its ratio.
// RULE13 - Pressure-only trigger stores latest temperature with it.
// RULE14 - Empty trigger still shows brief busy indication.
// RULE15 - FIFO mode: 0 off, 1 stop when full, 2/3 overwrite.
// RULE16 - Nonzero mode starts storage until mode written off.
// RULE17 - Threshold flag when unread count reaches 1..31; zero never.
// RULE18 - Filter: y = y - y/k + x/k.
// RULE19 - First result after enabling seeds filter; only off-on restarts.
// RULE20 - FIFO holds 32 pairs, first in first out.
// RULE21 - Stop mode accepts until 32 stored, then discards.
// RULE22 - Overwrite mode replaces oldest entries circularly.
// RULE23 - Read advances pointer at start of transfer.
// RULE24 - Mode off empties FIFO and resets pointers.
// RULE25 - Overwrite mode keeps at most 31 retrievable.
// RULE26 - Reset returns configuration to defaults.
// RULE27 - Reserved bits ignored on write, read as zero.
module sms_sequencer #(
  parameter int DW = 24,
  parameter int AW = 5,
  parameter int DELAY_SCALE = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_cmd,
  input wire logic conv_wr,
  input wire logic [15:0] conv_wdata,
  output logic [15:0] pressure_setup,
  output logic [15:0] temperature_setup,
  input wire logic conv_sel_temp,
  input wire logic oper_wr,
  input wire logic [15:0] oper_wdata,
  output logic [15:0] operating_setup,
  input wire logic start_cmd,
  input wire logic start_temp,
  input wire logic start_press,
  output logic cmd_rejected,
  output logic auto_active,
  output logic adc_start,
  output logic adc_is_temp,
  output logic [2:0] oversampling_select,
  input wire logic adc_done,
  input wire logic [DW-1:0] adc_data,
  output logic [DW-1:0] press_result,
  output logic [DW-1:0] temp_result,
  output logic [1:0] press_res_code,
  output logic [1:0] temp_res_code,
  output logic busy,
  input wire logic fifo_rd,
  output logic fifo_rd_valid,
  output logic [DW-1:0] fifo_press,
  output logic [DW-1:0] fifo_temp,
  output logic [AW:0] fifo_count,
  output logic fifo_full_flag,
  output logic fifo_thr_flag
);
  localparam int DEPTH = `SMS_FIFO_DEPTH;
  localparam longint MS_CYC = longint'(`SMS_CLK_HZ) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] ratio_of(input logic [15:0] w); // RULE2
    logic [2:0] c;
    c = w[`SMS_RATIO_MSB:`SMS_RATIO_LSB];
    case (c)
      3'h0: ratio_of = 6'h00;
      3'h1: ratio_of = 6'h01;
      3'h2: ratio_of = 6'h02;
      3'h3: ratio_of = 6'h04;
      3'h4: ratio_of = 6'h08;
      3'h5: ratio_of = 6'h10;
      default: ratio_of = 6'h20;
    endcase
  endfunction

  function automatic logic [2:0] fshift(input logic [15:0] w); // RULE3
    logic [2:0] c;
    c = w[`SMS_FILT_MSB:`SMS_FILT_LSB];
    fshift = (c > 3'h5) ? 3'h5 : c;
  endfunction

  function automatic logic [DW-1:0] filt(input logic [DW-1:0] y, input logic [DW-1:0] x,
                                         input logic [2:0] s); // RULE18
    filt = y - (y >> s) + (x >> s);
  endfunction

  function automatic logic [39:0] delay_cycles(input logic [3:0] c); // RULE7
    logic [39:0] ms;
    case (c)
      4'h1: ms = 40'd5;
      4'h2: ms = 40'd10;
      4'h3: ms = 40'd20;
      4'h4: ms = 40'd50;
      4'h5: ms = 40'd100;
      4'h6: ms = 40'd200;
      4'h7: ms = 40'd500;
      4'h8: ms = 40'd1000;
      4'h9: ms = 40'd2000;
      4'ha: ms = 40'd5000;
      4'hb: ms = 40'd10000;
      4'hc: ms = 40'd20000;
      4'h0: ms = 40'd0;
      default: ms = 40'd60000;
    endcase
    delay_cycles = (ms * 40'(MS_CYC)) / 40'(DELAY_SCALE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] next_pressure_setup, next_temperature_setup, next_operating_setup;
  logic [1:0] mode;
  logic [3:0] dly;
  logic [4:0] thr;
  logic clr_cfg;

  assign clr_cfg = rst | reset_cmd; // RULE26
  assign mode = operating_setup[`SMS_MODE_MSB:`SMS_MODE_LSB];
  assign dly = operating_setup[`SMS_DLY_MSB:`SMS_DLY_LSB];
  assign thr = operating_setup[`SMS_THR_MSB:`SMS_THR_LSB];
  logic [2:0] ovs_code;
  assign ovs_code = adc_is_temp ? temperature_setup[`SMS_OVS_MSB:`SMS_OVS_LSB]
                                : pressure_setup[`SMS_OVS_MSB:`SMS_OVS_LSB];
  assign oversampling_select = (ovs_code == 3'h7) ? 3'h6 : ovs_code; // RULE5

  always_comb
  begin
    next_pressure_setup = pressure_setup;
    next_temperature_setup = temperature_setup;
    next_operating_setup = operating_setup;
    if (conv_wr && !auto_active) // RULE10
    begin
      if (conv_sel_temp)
        next_temperature_setup = conv_wdata & `SMS_CONV_MASK; // RULE1 RULE27
      else
        next_pressure_setup = conv_wdata & `SMS_CONV_MASK; // RULE1 RULE27
    end
    if (oper_wr)
      next_operating_setup = oper_wdata & `SMS_OPER_MASK; // RULE6 RULE27
  end

  always_ff @(posedge clk)
  begin
    if (clr_cfg)
    begin
      pressure_setup <= `SMS_RESET_WORD;
      temperature_setup <= `SMS_RESET_WORD;
      operating_setup <= `SMS_RESET_WORD;
    end
    else
    begin
      pressure_setup <= next_pressure_setup;
      temperature_setup <= next_temperature_setup;
      operating_setup <= next_operating_setup;
    end
  end

  assign press_res_code = pressure_setup[`SMS_RES_MSB:`SMS_RES_LSB]; // RULE4
  assign temp_res_code = temperature_setup[`SMS_RES_MSB:`SMS_RES_LSB]; // RULE4
  assign cmd_rejected = auto_active & (start_cmd | conv_wr); // RULE10

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: converts T first, then P, then stores a pair
  sms_pkg::sms_state_t state, next_state;
  logic [39:0] tmr, next_tmr;
  logic [5:0] trig, next_trig;
  logic want_t, want_p, next_want_t, next_want_p;
  logic next_auto, is_auto, next_is_auto, store_pulse;
  logic [2:0] bcnt, next_bcnt;
  logic [5:0] pr, tr;

  assign pr = ratio_of(pressure_setup);
  assign tr = ratio_of(temperature_setup);
  assign next_auto = (dly != 4'h0) && (pr != 6'h00 || tr != 6'h00); // RULE9
  assign busy = (state != sms_pkg::sms_idle) && (state != sms_pkg::sms_wait);
  assign adc_start = (state == sms_pkg::sms_conv_t || state == sms_pkg::sms_conv_p) && !adc_done
                     && (tmr == 40'd0);
  assign adc_is_temp = (state == sms_pkg::sms_conv_t);
  assign store_pulse = (state == sms_pkg::sms_store);

  always_comb
  begin
    next_state = state;
    next_tmr = tmr;
    next_trig = trig;
    next_want_t = want_t;
    next_want_p = want_p;
    next_is_auto = is_auto;
    next_bcnt = bcnt;
    case (state)
      sms_pkg::sms_idle:
      begin
        next_trig = 6'h00;
        if (next_auto)
        begin
          next_is_auto = 1'b1;
          next_want_t = (tr != 6'h00); // RULE12
          next_want_p = (pr != 6'h00);
          next_state = next_want_t ? sms_pkg::sms_conv_t : sms_pkg::sms_conv_p;
        end
        else if (start_cmd && (start_temp || start_press))
        begin
          next_is_auto = 1'b0;
          next_want_t = start_temp;
          next_want_p = start_press;
          next_state = start_temp ? sms_pkg::sms_conv_t : sms_pkg::sms_conv_p;
        end
      end
      sms_pkg::sms_conv_t:
      begin
        next_tmr = 40'd0;
        if (adc_done)
          next_state = want_p ? sms_pkg::sms_conv_p : sms_pkg::sms_store;
      end
      sms_pkg::sms_conv_p:
      begin
        next_tmr = 40'd0;
        if (adc_done)
          next_state = sms_pkg::sms_store;
      end
      sms_pkg::sms_store, sms_pkg::sms_busy:
      begin
        if (state == sms_pkg::sms_busy && bcnt != 3'h0)
          next_bcnt = bcnt - 3'h1; // RULE14
        else if (is_auto && dly != 4'h0)
        begin
          next_tmr = delay_cycles(dly); // RULE8
          next_state = sms_pkg::sms_wait;
        end
        else
          next_state = sms_pkg::sms_idle; // RULE11
      end
      sms_pkg::sms_wait:
      begin
        if (dly == 4'h0)
          next_state = sms_pkg::sms_idle; // RULE11
        else if (tmr > 40'd1)
          next_tmr = tmr - 40'd1;
        else
        begin
          next_trig = (trig == 6'h1f) ? 6'h00 : trig + 6'h01;
          next_want_t = (tr != 6'h00) && ((next_trig & (tr - 6'h01)) == 6'h00); // RULE12
          next_want_p = (pr != 6'h00) && ((next_trig & (pr - 6'h01)) == 6'h00); // RULE12
          next_bcnt = 3'(`SMS_BUSY_CYCLES);
          if (next_want_t)
            next_state = sms_pkg::sms_conv_t;
          else if (next_want_p)
            next_state = sms_pkg::sms_conv_p;
          else
            next_state = sms_pkg::sms_busy; // RULE14
        end
      end
      default: next_state = sms_pkg::sms_idle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || reset_cmd)
    begin
      state <= sms_pkg::sms_idle;
      tmr <= 40'd0;
      trig <= 6'h00;
      want_t <= 1'b0;
      want_p <= 1'b0;
      is_auto <= 1'b0;
      bcnt <= 3'h0;
    end
    else
    begin
      state <= next_state;
      tmr <= next_tmr;
      trig <= next_trig;
      want_t <= next_want_t;
      want_p <= next_want_p;
      is_auto <= next_is_auto;
      bcnt <= next_bcnt;
    end
  end

  // Active from the cycle the delay lands, so no config write slips in before the start
  assign auto_active = next_auto || (is_auto && state != sms_pkg::sms_idle); // RULE9 RULE10

  ////////////////////////////////////////////////////////////////////////////
  // Results and filter; seed flag drops whenever filter code reads off
  logic [DW-1:0] next_press_result, next_temp_result;
  logic p_seed, t_seed, next_p_seed, next_t_seed;
  logic [2:0] ps, ts;

  assign ps = fshift(pressure_setup);
  assign ts = fshift(temperature_setup);

  always_comb
  begin
    next_press_result = press_result;
    next_temp_result = temp_result;
    next_p_seed = (ps != 3'h0) & p_seed; // RULE19
    next_t_seed = (ts != 3'h0) & t_seed; // RULE19
    if (adc_done && state == sms_pkg::sms_conv_t)
    begin
      next_temp_result = (ts != 3'h0 && t_seed) ? filt(temp_result, adc_data, ts) : adc_data;
      next_t_seed = (ts != 3'h0);
    end
    if (adc_done && state == sms_pkg::sms_conv_p)
    begin
      next_press_result = (ps != 3'h0 && p_seed) ? filt(press_result, adc_data, ps) : adc_data;
      next_p_seed = (ps != 3'h0);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      press_result <= '0;
      temp_result <= '0;
      p_seed <= 1'b0;
      t_seed <= 1'b0;
    end
    else
    begin
      press_result <= next_press_result;
      temp_result <= next_temp_result;
      p_seed <= next_p_seed;
      t_seed <= next_t_seed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair FIFO; temp_result already holds the latest T for P-only triggers
  sms_mem_if #(.AW(AW), .DW(2*DW)) mif ();
  sms_pair_mem #(.AW(AW), .DW(2*DW)) u_mem (.clk(clk), .port(mif.mem));

  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] next_count;
  logic next_rd_valid, do_wr, do_rd, is_upd;

  assign is_upd = mode[1]; // RULE15
  assign do_rd = fifo_rd && fifo_count != '0;
  assign do_wr = store_pulse && mode != 2'h0 && (is_upd || fifo_count != (AW+1)'(DEPTH)); // RULE16 RULE21
  assign mif.we = do_wr;
  assign mif.waddr = wp;
  assign mif.wdata = {next_temp_result, next_press_result}; // RULE13
  assign mif.raddr = rp;
  assign {fifo_temp, fifo_press} = mif.rdata; // RULE20

  always_comb
  begin
    next_wp = wp;
    next_rp = rp;
    next_count = fifo_count;
    next_rd_valid = do_rd;
    if (do_rd)
    begin
      next_rp = rp + 1'b1; // RULE23
      next_count = next_count - 1'b1;
    end
    if (do_wr)
    begin
      next_wp = wp + 1'b1; // RULE22
      if (is_upd && fifo_count >= (AW+1)'(DEPTH - 1) && !do_rd)
        next_rp = rp + 1'b1; // RULE25
      else
        next_count = next_count + 1'b1;
    end
    if (mode == 2'h0)
    begin
      next_wp = '0; // RULE24
      next_rp = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || reset_cmd)
    begin
      wp <= '0;
      rp <= '0;
      fifo_count <= '0;
      fifo_rd_valid <= 1'b0;
    end
    else
    begin
      wp <= next_wp;
      rp <= next_rp;
      fifo_count <= next_count;
      fifo_rd_valid <= next_rd_valid;
    end
  end

  assign fifo_full_flag = (fifo_count == (AW+1)'(DEPTH));
  assign fifo_thr_flag = (thr != 5'h00) && (fifo_count >= {1'b0, thr}); // RULE17
endmodule
`default_nettype wire

// *** tb/sms_sequencer_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module sms_checker #(
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_cmd,
  input wire logic conv_wr,
  input wire logic oper_wr,
  input wire logic [15:0] oper_wdata,
  input wire logic start_cmd,
  input wire logic [15:0] pressure_setup,
  input wire logic [15:0] temperature_setup,
  input wire logic [15:0] operating_setup,
  input wire logic cmd_rejected,
  input wire logic auto_active,
  input wire logic [AW:0] fifo_count,
  input wire logic fifo_full_flag,
  input wire logic fifo_thr_flag,
  input wire logic [1:0] press_res_code,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_reserved_zero: assert property ((pressure_setup | temperature_setup) < 16'h0800)
    else $error("reserved config bits set");
  a_unused_zero: assert property ((operating_setup & 16'he030) == 16'h0000)
    else $error("unused operation bits set");
  a_reject_auto: assert property ((start_cmd || conv_wr) |-> cmd_rejected == auto_active)
    else $error("command rejection wrong");
  a_config_locked: assert property (conv_wr && auto_active && !reset_cmd |=>
    $stable(pressure_setup) && $stable(temperature_setup)) else $error("config changed in auto");
  a_auto_start: assert property ((operating_setup[3:0] != 4'h0 &&
    (pressure_setup[10:8] != 3'h0 || temperature_setup[10:8] != 3'h0)) |-> auto_active)
    else $error("auto mode not started");
  a_auto_stop: assert property ((operating_setup[3:0] == 4'h0 ||
    (pressure_setup[10:8] == 3'h0 && temperature_setup[10:8] == 3'h0)) && !busy && !oper_wr
    |=> !auto_active) else $error("auto mode not stopped");
  a_depth_cap: assert property (fifo_count <= (operating_setup[7] ? 31 : 32))
    else $error("fifo count above capacity");
  // Mode lands one edge after the write, the emptied count one edge later
  a_off_empties: assert property (oper_wr && oper_wdata[7:6] == 2'b00 |=> ##1 fifo_count == '0)
    else $error("fifo not emptied");
  a_thr_zero: assert property (operating_setup[12:8] == 5'h00 &&
    $past(operating_setup[12:8]) == 5'h00 |-> !fifo_thr_flag) else $error("threshold flag at zero");
  // Flag is decoded combinationally from the count, so it never trails it
  a_full_flag: assert property (fifo_count == 32 |-> ##[0:1] fifo_full_flag)
    else $error("full flag missing");
  a_res_code: assert property (press_res_code == pressure_setup[4:3])
    else $error("resolution code wrong");
  c_auto: cover property (auto_active && cmd_rejected);
  c_full: cover property (fifo_full_flag);
  c_thr: cover property (fifo_thr_flag);
endmodule
bind sms_sequencer sms_checker #(.AW(AW)) chk (.clk, .rst, .reset_cmd, .conv_wr, .oper_wr,
  .oper_wdata, .start_cmd, .pressure_setup, .temperature_setup, .operating_setup, .cmd_rejected,
  .auto_active, .fifo_count, .fifo_full_flag, .fifo_thr_flag, .press_res_code, .busy);
`default_nettype wire

// *** tb/sms_adc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sms_adc_model #(
  parameter int DW = 24,
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic restart,
  input wire logic adc_start,
  input wire logic adc_is_temp,
  output logic adc_done,
  output logic [DW-1:0] adc_data
);
  int cnt = 0;
  int pn = 0;
  int tn = 0;
  always_ff @(posedge clk)
  begin
    if (restart)
    begin
      adc_done <= 1'b0;
      cnt <= 0;
      pn <= 0;
      tn <= 0;
      adc_data <= '0;
    end
    else if (adc_start && !adc_done && cnt == LAT - 1)
    begin
      adc_done <= 1'b1;
      cnt <= 0;
      adc_data <= DW'(adc_is_temp ? 32'h800 + tn : 16 * (pn + 1));
      if (adc_is_temp)
        tn <= tn + 1;
      else
        pn <= pn + 1;
    end
    else
    begin
      adc_done <= 1'b0;
      // Data is only valid with done; toggle so stale values match only on every other cycle
      adc_data <= ~adc_data;
      cnt <= (adc_start && !adc_done) ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// *** tb/sms_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sms_sequencer_test;
  logic clk, rst = 1'b1, reset_cmd = 1'b0, conv_wr = 1'b0, conv_sel_temp = 1'b0, oper_wr = 1'b0;
  logic start_cmd = 1'b0, start_temp = 1'b0, start_press = 1'b0, fifo_rd = 1'b0, restart = 1'b0;
  logic [15:0] conv_wdata = 16'h0000, oper_wdata = 16'h0000;
  logic cmd_rejected, auto_active, adc_start, adc_is_temp, adc_done, busy;
  logic fifo_rd_valid, fifo_full_flag, fifo_thr_flag;
  logic [15:0] pressure_setup, temperature_setup, operating_setup;
  logic [23:0] adc_data, press_result, temp_result, fifo_press, fifo_temp;
  logic [1:0] press_res_code, temp_res_code;
  logic [2:0] oversampling_select;
  logic [5:0] fifo_count;
  int failures = 0;
  int comparisons = 0;
  // Short delays keep automatic mode within a few cycles per trigger
  sms_sequencer #(.DELAY_SCALE(10000)) dut (.clk, .rst, .reset_cmd, .conv_wr, .conv_wdata,
    .pressure_setup, .temperature_setup, .conv_sel_temp, .oper_wr, .oper_wdata,
    .operating_setup, .start_cmd, .start_temp, .start_press, .cmd_rejected, .auto_active,
    .adc_start, .adc_is_temp, .oversampling_select, .adc_done, .adc_data, .press_result,
    .temp_result, .press_res_code, .temp_res_code, .busy, .fifo_rd, .fifo_rd_valid,
    .fifo_press, .fifo_temp, .fifo_count, .fifo_full_flag, .fifo_thr_flag);
  sms_adc_model #(.LAT(4)) adc (.clk, .restart, .adc_start, .adc_is_temp, .adc_done, .adc_data);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle_wait;
    int n = 0;
    while (busy !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      conclude();
    end
    @(posedge clk);
    #1;
  endtask
  task automatic wcfg(input logic t, input logic [15:0] d);
    @(posedge clk);
    conv_sel_temp <= t;
    conv_wdata <= d;
    conv_wr <= 1'b1;
    @(posedge clk);
    conv_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic woper(input logic [15:0] d);
    @(posedge clk);
    oper_wdata <= d;
    oper_wr <= 1'b1;
    @(posedge clk);
    oper_wr <= 1'b0;
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    #1;
  endtask
  task automatic conv(input logic t, input logic p);
    @(posedge clk);
    start_temp <= t;
    start_press <= p;
    start_cmd <= 1'b1;
    @(posedge clk);
    start_cmd <= 1'b0;
    @(posedge clk);
    #1;
    idle_wait();
  endtask
  task automatic rd(input logic [23:0] p, input logic [23:0] t);
    @(posedge clk);
    fifo_rd <= 1'b1;
    @(posedge clk);
    fifo_rd <= 1'b0;
    // Read data stands only while valid; the memory then follows the new pointer
    #1;
    chk(fifo_rd_valid, 1'b1);
    chk({fifo_press, fifo_temp}, {p, t});
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk({pressure_setup, temperature_setup, operating_setup}, 48'h0);
    wcfg(1'b0, 16'hffff);
    wcfg(1'b1, 16'hf8e7);
    woper(16'hffff);
    chk(pressure_setup, 16'h07ff);
    chk(temperature_setup, 16'h00e7);
    chk(operating_setup, 16'h1fcf);
    @(posedge clk);
    reset_cmd <= 1'b1;
    @(posedge clk);
    reset_cmd <= 1'b0;
    @(posedge clk);
    #1;
    chk({pressure_setup, temperature_setup, operating_setup}, 48'h0);
  endtask
  task automatic t_filter;
    woper(16'h0000);
    wcfg(1'b0, 16'h0037);
    chk(press_res_code, 2'b10);
    chk(oversampling_select, 3'h6);
    conv(1'b0, 1'b1);
    chk(press_result, 24'd16);
    conv(1'b0, 1'b1);
    chk(press_result, 24'd24);
    wcfg(1'b0, 16'h0000);
  endtask
  task automatic t_fifo(input logic [15:0] mode);
    woper(mode);
    for (int i = 1; i <= 33; i++)
    begin
      conv(1'b1, 1'b1);
      if (i == 4 || i == 5)
        chk(fifo_thr_flag, mode[8] && i == 5);
    end
  endtask
  task automatic t_auto;
    logic [5:0] c;
    int n = 0;
    woper(16'h0001);
    chk(auto_active, 1'b0);
    woper(16'h0000);
    wcfg(1'b0, 16'h0100);
    wcfg(1'b1, 16'h0300);
    woper(16'h0041);
    chk(auto_active, 1'b1);
    @(posedge clk);
    conv_wdata <= 16'h0000;
    conv_wr <= 1'b1;
    #1;
    chk(cmd_rejected, 1'b1);
    @(posedge clk);
    conv_wr <= 1'b0;
    while (fifo_count < 6'd8 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000)
    begin
      failures++;
      $display("ERROR %0t: auto fill timeout", $time);
      conclude();
    end
    woper(16'h0040);
    chk({auto_active, temperature_setup}, 17'h00300);
    idle_wait();
    c = fifo_count;
    repeat (50) @(posedge clk);
    chk(fifo_count, c);
    for (int i = 0; i < 8; i++)
      rd(24'(16 * (i + 1)), 24'h800 + 24'(i / 4));
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_regs();
    t_filter();
    t_fifo(16'h0540);
    chk({fifo_count, fifo_full_flag}, {6'd32, 1'b1});
    rd(24'd16, 24'h800);
    rd(24'd32, 24'h801);
    woper(16'h0000);
    chk(fifo_count, 6'd0);
    t_fifo(16'h0080);
    chk(fifo_count, 6'd31);
    rd(24'd48, 24'h802);
    woper(16'h0000);
    t_auto();
    conclude();
  end
endmodule
`default_nettype wire
